// ### design/bus_events.v
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// edge and condition detection on the synchronised lines
module bus_events (
   input  wire i_clock,
   input  wire i_rst,
   input  wire i_scl,
   input  wire i_sda,
   output wire o_scl_rise,
   output wire o_scl_fall,
   output wire o_start,
   output wire o_stop
);
   reg scl_d_ff;
   reg sda_d_ff;
   always @(posedge i_clock) begin
      if (i_rst) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= i_scl;
         sda_d_ff <= i_sda;
      end
   end
   assign o_scl_rise = i_scl & ~scl_d_ff;
   assign o_scl_fall = ~i_scl & scl_d_ff;
   // sda moving while scl stays high
   assign o_start = scl_d_ff & i_scl & sda_d_ff & ~i_sda;
   assign o_stop  = scl_d_ff & i_scl & ~sda_d_ff & i_sda;
endmodule // bus_events
`default_nettype wire

// ### design/dual_address_i2c_slave.v
`timescale 1ns/1ns
`default_nettype none
`include "i2c_slave_defines.vh"
// ==========================================================
// Functional notes
// - sda falling while scl high begins a new transfer
// - sda rising while scl high ends the current transfer
// - a start without preceding stop restarts the transfer
// - sda changes only with scl low; bits sampled on scl rising
// - device drives its bits after scl falling, valid at next rise
// - ninth bit is acknowledge from receiver, low ack, high nack
// - written bytes arrive msb first, then slave acknowledges
// - master nacks last read byte; device then releases sda
// - first byte after start: seven address bits plus read/write
// - auxiliary space answers at address byte A0h
// - main space at A2h, or at the byte held in location 8Ch when enabled
// - read/write bit 0 writes, 1 reads
// - unmatched address: stay off bus until next start
// - main address equal to A0h hides the auxiliary space
// - second byte of a write is the memory location
// - write data wraps inside its eight-byte row
// - no address acknowledge during page write after stop
// - reads start at the current location counter
// - reads cross rows and roll FFh to 00h
module dual_address_i2c_slave #(
   parameter PAGE_WRITE_CYCLES = `PAGE_WRITE_CYCLES
) (
   input  wire       i_clock,
   input  wire       i_rst,
   input  wire       i_scl,
   input  wire       i_sda,
   output wire       o_sda,
   output wire       o_sda_oe,
   input  wire       i_main_addr_en,
   output wire       o_busy
);
   localparam ST_IDLE  = 3'h0;
   localparam ST_ADDR  = 3'h1;
   localparam ST_LOC   = 3'h2;
   localparam ST_WDATA = 3'h3;
   localparam ST_RDATA = 3'h4;
   localparam ST_RACK  = 3'h5;

   wire scl_s;
   wire sda_s;
   wire scl_rise;
   wire scl_fall;
   wire start_c;
   wire stop_c;

   reg [2:0]  state_ff;
   reg [3:0]  bit_ff;
   reg [7:0]  shift_ff;
   reg        aux_sel_ff;
   reg [7:0]  loc_ff;
   reg        drive_ff;
   reg [7:0]  tx_ff;
   reg        ack_pend_ff;
   reg        dirty_ff;
   reg [31:0] busy_cnt_ff;
   reg [7:0]  main_mem [0:255];
   reg [7:0]  aux_mem  [0:255];
   reg [7:0]  main_addr_ff;

   // ==========================================================
   // pin sampling
   pin_sync #(.RESET_VAL(1'b1)) u_scl_sync (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_async (i_scl),
      .o_sync  (scl_s)
   );
   pin_sync #(.RESET_VAL(1'b1)) u_sda_sync (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_async (i_sda),
      .o_sync  (sda_s)
   );
   bus_events u_events (
      .i_clock    (i_clock),
      .i_rst      (i_rst),
      .i_scl      (scl_s),
      .i_sda      (sda_s),
      .o_scl_rise (scl_rise),
      .o_scl_fall (scl_fall),
      .o_start    (start_c),
      .o_stop     (stop_c)
   );

   // ==========================================================
   // address decode
   function [1:0] match_addr;
      input [7:0] abyte;
      input [7:0] main_a;
      begin
         match_addr = 2'b00;
         if (abyte[7:1] == main_a[7:1]) begin
            match_addr = 2'b01;
         end else if (abyte[7:1] == `AUX_ADDR_BYTE >> 1) begin
            match_addr = 2'b10;
         end
      end
   endfunction

   // row-bounded increment used for write data
   function [7:0] row_inc;
      input [7:0] loc;
      begin
         row_inc = {loc[7:3], loc[2:0] + 3'h1};
      end
   endfunction

   wire [7:0] rx_byte  = {shift_ff[6:0], sda_s};
   wire [1:0] hit      = match_addr(rx_byte, main_addr_ff);
   wire       busy     = (busy_cnt_ff != 32'h0);
   wire [7:0] rd_byte  = aux_sel_ff ? aux_mem[loc_ff] : main_mem[loc_ff];

   // main address latches from location 8Ch when enabled
   always @(posedge i_clock) begin
      if (i_rst) begin
         main_addr_ff <= `MAIN_ADDR_DEFAULT;
      end else if (i_main_addr_en) begin
         main_addr_ff <= main_mem[`MAIN_ADDR_LOC];
      end else begin
         main_addr_ff <= `MAIN_ADDR_DEFAULT;
      end
   end

   // ==========================================================
   // page-write busy timer, started by stop after written data
   always @(posedge i_clock) begin
      if (i_rst) begin
         busy_cnt_ff <= 32'h0;
      end else if (stop_c && dirty_ff) begin
         busy_cnt_ff <= PAGE_WRITE_CYCLES;
      end else if (busy) begin
         busy_cnt_ff <= busy_cnt_ff - 32'h1;
      end
   end
   assign o_busy = busy;

   // ==========================================================
   // memory write
   always @(posedge i_clock) begin
      if (!i_rst && state_ff == ST_WDATA && scl_rise && bit_ff == 4'h7) begin
         if (aux_sel_ff) begin
            aux_mem[loc_ff] <= rx_byte;
         end else begin
            main_mem[loc_ff] <= rx_byte;
         end
      end
   end

   // ==========================================================
   // protocol engine
   always @(posedge i_clock) begin
      if (i_rst) begin
         state_ff    <= ST_IDLE;
         bit_ff      <= 4'h0;
         shift_ff    <= 8'h00;
         aux_sel_ff  <= 1'b0;
         loc_ff      <= `LOC_BOTTOM;
         ack_pend_ff <= 1'b0;
         dirty_ff    <= 1'b0;
      end else if (start_c) begin
         state_ff    <= ST_ADDR;
         bit_ff      <= 4'h0;
         ack_pend_ff <= 1'b0;
      end else if (stop_c) begin
         state_ff    <= ST_IDLE;
         ack_pend_ff <= 1'b0;
         dirty_ff    <= 1'b0;
      end else if (scl_rise) begin
         case (state_ff)
            ST_ADDR, ST_LOC, ST_WDATA: begin
               if (bit_ff < `BITS_PER_BYTE) begin
                  shift_ff <= rx_byte;
                  bit_ff   <= bit_ff + 4'h1;
                  if (bit_ff == 4'h7) begin
                     case (state_ff)
                        ST_ADDR: begin
                           if (hit == 2'b00 || busy) begin
                              state_ff <= ST_IDLE;
                           end else begin
                              aux_sel_ff  <= hit[1];
                              ack_pend_ff <= 1'b1;
                           end
                        end
                        ST_LOC: begin
                           loc_ff      <= rx_byte;
                           ack_pend_ff <= 1'b1;
                        end
                        ST_WDATA: begin
                           loc_ff      <= row_inc(loc_ff);
                           dirty_ff    <= 1'b1;
                           ack_pend_ff <= 1'b1;
                        end
                        default: begin
                           ack_pend_ff <= 1'b0;
                        end
                     endcase
                  end
               end else begin
                  // ninth bit done by the device acknowledge
                  bit_ff <= 4'h0;
                  if (state_ff == ST_ADDR) begin
                     state_ff <= shift_ff[0] ? ST_RDATA : ST_LOC;
                  end else begin
                     state_ff <= ST_WDATA;
                  end
               end
            end
            ST_RDATA: begin
               bit_ff <= bit_ff + 4'h1;
               if (bit_ff == 4'h7) begin
                  state_ff <= ST_RACK;
                  loc_ff   <= loc_ff + 8'h01;
               end
            end
            ST_RACK: begin
               bit_ff <= 4'h0;
               // ack from master asks for another byte
               state_ff <= sda_s ? ST_IDLE : ST_RDATA;
            end
            default: begin
               bit_ff <= 4'h0;
            end
         endcase
      end else if (scl_fall) begin
         // acknowledge slot begins; shift_ff keeps the read/write bit for the ninth rise
         ack_pend_ff <= 1'b0;
      end
   end

   // ==========================================================
   // sda driver
   // changes on a synchronised scl fall and otherwise only clears at a start or stop, so the line never moves
   // while scl is high, where a release would look like a stop
   always @(posedge i_clock) begin
      if (i_rst) begin
         drive_ff <= 1'b0;
         tx_ff    <= 8'h00;
      end else if (start_c || stop_c) begin
         drive_ff <= 1'b0;
      end else if (scl_fall) begin
         if (ack_pend_ff) begin
            drive_ff <= 1'b1;
         end else if (state_ff == ST_RDATA && bit_ff == 4'h0) begin
            // first bit of a read byte, from the current location
            drive_ff <= ~rd_byte[7];
            tx_ff    <= {rd_byte[6:0], 1'b0};
         end else if (state_ff == ST_RDATA) begin
            drive_ff <= ~tx_ff[7];
            tx_ff    <= {tx_ff[6:0], 1'b0};
         end else begin
            // master's acknowledge slot, receive bits and idle
            drive_ff <= 1'b0;
         end
      end
   end

   // open drain: the pin is only ever pulled low
   assign o_sda    = 1'b0;
   assign o_sda_oe = drive_ff;
endmodule // dual_address_i2c_slave
`default_nettype wire

// ### design/pin_sync.v
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// two-stage synchroniser, first stage read only by the second
module pin_sync #(
   parameter RESET_VAL = 1'b1
) (
   input  wire i_clock,
   input  wire i_rst,
   input  wire i_async,
   output wire o_sync
);
   reg meta_ff;
   reg sync_ff;
   always @(posedge i_clock) begin
      if (i_rst) begin
         meta_ff <= RESET_VAL;
         sync_ff <= RESET_VAL;
      end else begin
         meta_ff <= i_async;
         sync_ff <= meta_ff;
      end
   end
   assign o_sync = sync_ff;
endmodule // pin_sync
`default_nettype wire

// ### dv/dual_address_i2c_slave_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "i2c_slave_defines.vh"
module dual_address_i2c_slave_bench;
   localparam int PW = 200;
   logic       i_clock = 1'b0;
   logic       i_rst = 1'b1;
   logic       main_en = 1'b0;
   wire        scl, sda_line, sda_out, sda_oe, busy;
   int         fail_count = 0;
   int         checked = 0;
   logic       nack;
   logic [7:0] rd;
   always #5 i_clock = ~i_clock;
   dual_address_i2c_slave #(.PAGE_WRITE_CYCLES(PW)) dut (
      .i_clock(i_clock), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_line), .o_sda(sda_out),
      .o_sda_oe(sda_oe), .i_main_addr_en(main_en), .o_busy(busy));
   i2c_master_model master (.i_clock(i_clock), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda_line(sda_line));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic send(input logic [7:0] b, input logic exp);
      master.write_byte(b, nack);
      check({7'h00, nack}, {7'h00, exp});
   endtask
   task automatic fetch(input logic last, input logic [7:0] exp);
      master.read_byte(last, rd);
      check(rd, exp);
   endtask
   task automatic settle();
      repeat (PW + 20) @(posedge i_clock);
      check({7'h00, busy}, 8'h00);
   endtask
   task automatic point(input logic [7:0] dev, input logic [7:0] loc);
      master.start_cond();
      send(dev, 1'b0);
      send(loc, 1'b0);
      master.start_cond();
      send(dev | 8'h01, 1'b0);
   endtask
   task automatic t_write_wrap();
      master.start_cond();
      send(`AUX_ADDR_BYTE, 1'b0);
      send(8'h06, 1'b0);
      send(8'h11, 1'b0);
      send(8'h22, 1'b0);
      send(8'h33, 1'b0);
      master.stop_cond();
      repeat (3) @(posedge i_clock);
      check({7'h00, busy}, 8'h01);
      master.start_cond();
      send(`AUX_ADDR_BYTE, 1'b1);
      master.stop_cond();
      settle();
   endtask
   task automatic t_read_back();
      point(`AUX_ADDR_BYTE, 8'h06);
      fetch(1'b0, 8'h11);
      fetch(1'b1, 8'h22);
      point(`AUX_ADDR_BYTE, 8'h00);
      fetch(1'b1, 8'h33);
      master.start_cond();
      send(8'h50, 1'b1);
      send(8'h00, 1'b1);
      master.stop_cond();
   endtask
   task automatic t_read_roll();
      master.start_cond();
      send(`AUX_ADDR_BYTE, 1'b0);
      send(`LOC_TOP, 1'b0);
      send(8'h5A, 1'b0);
      master.stop_cond();
      settle();
      point(`AUX_ADDR_BYTE, `LOC_TOP);
      fetch(1'b0, 8'h5A);
      fetch(1'b1, 8'h33);
      master.stop_cond();
   endtask
   task automatic t_main_alias();
      master.start_cond();
      send(`MAIN_ADDR_DEFAULT, 1'b0);
      send(`MAIN_ADDR_LOC, 1'b0);
      send(`AUX_ADDR_BYTE, 1'b0);
      master.stop_cond();
      settle();
      main_en <= 1'b1;
      master.start_cond();
      send(`MAIN_ADDR_DEFAULT, 1'b1);
      master.start_cond();
      send(`AUX_ADDR_BYTE, 1'b0);
      send(8'h06, 1'b0);
      send(8'h77, 1'b0);
      master.stop_cond();
      settle();
      main_en <= 1'b0;
      point(`MAIN_ADDR_DEFAULT, 8'h06);
      fetch(1'b1, 8'h77);
      point(`AUX_ADDR_BYTE, 8'h06);
      fetch(1'b1, 8'h11);
      master.stop_cond();
   endtask
   task automatic test_done();
      if (fail_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge i_clock);
      i_rst <= 1'b0;
      repeat (4) @(posedge i_clock);
      t_write_wrap();
      t_read_back();
      t_read_roll();
      t_main_alias();
      test_done();
   end
   // whole run is near 4000 cycles
   initial begin
      #500000;
      fail_count++;
      test_done();
   end
endmodule  // dual_address_i2c_slave_bench
bind dual_address_i2c_slave dual_address_i2c_slave_sva #(.PAGE_WRITE_CYCLES(PAGE_WRITE_CYCLES)) sva (
   .i_clock(i_clock), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
   .o_sda_oe(o_sda_oe), .i_main_addr_en(i_main_addr_en), .o_busy(o_busy));
`default_nettype wire

// ### dv/dual_address_i2c_slave_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// port checks on the slave
module dual_address_i2c_slave_sva #(
   parameter PAGE_WRITE_CYCLES = 200
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda,
   input wire logic o_sda_oe,
   input wire logic i_main_addr_en,
   input wire logic o_busy
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   a_pull_only: assert property (o_sda == 1'b0) else $error("sda driven high");
   a_reset_quiet: assert property (disable iff (1'b0) i_rst |=> !o_sda_oe && !o_busy)
      else $error("drive or busy after reset");
   a_stable_high: assert property ($rose(i_scl) |-> $stable(o_sda_oe) [*3])
      else $error("sda drive moved while scl high");
   a_drive_length: assert property ($rose(o_sda_oe) |-> o_sda_oe [*7])
      else $error("driven bit too short");
   a_busy_after_stop: assert property ($rose(o_busy) |-> i_scl && i_sda)
      else $error("busy without stop");
   a_busy_long: assert property ($rose(o_busy) |-> o_busy [*8])
      else $error("busy too short");
   a_busy_no_ack: assert property (o_busy |-> !o_sda_oe) else $error("answered while busy");
   a_drive_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
      else $error("sda drive changed while scl high");
   a_stop_release: assert property (i_scl && $rose(i_sda) |=> !o_sda_oe [*3])
      else $error("drive after stop");
endmodule  // dual_address_i2c_slave_sva
`default_nettype wire

// ### dv/i2c_master_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// bus master; scl rests high between frames
module i2c_master_model (
   input  wire logic i_clock,
   input  wire logic i_sda_oe,
   output var  logic o_scl,
   output wire logic o_sda_line
);
   logic pull_low;
   initial begin
      o_scl = 1'b1;
      pull_low = 1'b0;
   end
   // pulled-up wire: high unless someone pulls
   assign o_sda_line = ~(pull_low | i_sda_oe);
   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   // low 5 cycles, high 3: the slave answer lands well before the rise
   task automatic xfer_bit(input logic b, output logic r);
      o_scl <= 1'b0;
      wait_clk(2);
      pull_low <= ~b;
      wait_clk(3);
      o_scl <= 1'b1;
      wait_clk(3);
      r = o_sda_line;
   endtask
   task automatic edge_cond(input logic first);
      o_scl <= 1'b0;
      wait_clk(2);
      pull_low <= first;
      wait_clk(3);
      o_scl <= 1'b1;
      wait_clk(3);
      pull_low <= ~first;
      wait_clk(3);
   endtask
   task automatic start_cond();
      edge_cond(1'b0);
   endtask
   task automatic stop_cond();
      edge_cond(1'b1);
   endtask
   task automatic write_byte(input logic [7:0] b, output logic nack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer_bit(b[i], r);
      xfer_bit(1'b1, nack);
   endtask
   task automatic read_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
      xfer_bit(nack, r);
   endtask
endmodule  // i2c_master_model
`default_nettype wire

// ### shared/i2c_slave_defines.vh
`ifndef I2C_SLAVE_DEFINES_VH
`define I2C_SLAVE_DEFINES_VH
// ==========================================================
// slave address bytes (read/write bit cleared)
`define AUX_ADDR_BYTE      8'hA0
`define MAIN_ADDR_DEFAULT  8'hA2
// location of the programmable main-space address byte
`define MAIN_ADDR_LOC      8'h8C
// ==========================================================
// memory geometry
`define ROW_BYTES          8
`define LOC_TOP            8'hFF
`define LOC_BOTTOM         8'h00
// ==========================================================
// bit counts
`define BITS_PER_BYTE      4'h8
`define ACK_BIT_INDEX      4'h9
// ==========================================================
// timing
`define CLK_PERIOD_NS      10
`define PAGE_WRITE_TIME_NS 10000
`define PAGE_WRITE_CYCLES  ((`PAGE_WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif
